// [rtl/asn_device.sv]
// asn_device: alarm status, sticky notify, enable and interrupt-select registers
// assumes a host on asn_if.dev and clk_en pulsing at the 4 MHz RC rate
//
// Functional notes
// - status reads live defect level, unlatched
// - rising status edge sets its sticky bit
// - sticky holds until host writes one
// - sticky sets only while enable bit is one
// - enable registers reset to all ones
// - cleared sticky sets again on next edge
// - all alarm logic runs on 4 MHz tick
// - sticky registers reset to all ones
// - host clears stickies, opens enables at start
// - host clears stickies after loading a profile
// - interrupt pin is NOR of selected stickies
// - interrupt selection configurable per sticky bit
// - host clears selected stickies to release pin
// - writing offset 0xff selects the page
// - page stays selected until rewritten
// - xo loss bit 4, cmon lock bit 5
// - outer lock loss of four plls, bits 3:0
// - holdover hold of four plls, bits 3:0
// - inner lock loss of four plls, bits 3:0
// - eight loader events in group a
// - loader timeout, data, stop errors bits 0-2
// - loader start, read-done timeout bits 3-4
`timescale 1ns/1ps
module asn_device #(
  parameter int SYNC_STAGES = 2
) (
  // clock, reset and 4 MHz tick
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // register port and interrupt pin
  asn_if.dev              bus,
  // pll alarms, pll n on bit n
  input  wire logic [asn_pkg::ASN_PLL_BITS-1:0] outer_lock_loss,
  input  wire logic [asn_pkg::ASN_PLL_BITS-1:0] inner_lock_loss,
  input  wire logic       pll0_holdover_hold,
  input  wire logic       pll1_holdover_hold,
  input  wire logic       pll2_holdover_hold,
  input  wire logic       pll3_holdover_hold,
  // loader events, group a
  input  wire logic       nvm_read_done,
  input  wire logic       nvm_crc_error,
  input  wire logic       nvm_arb_lost,
  input  wire logic       nvm_page_ident_error,
  input  wire logic       nvm_device_ident_error,
  input  wire logic       nvm_size_error,
  input  wire logic       nvm_word_addr_error,
  input  wire logic       nvm_dev_addr_error,
  // loader defects, group b: start timeout, data, stop, start, read-done timeout
  input  wire logic [asn_pkg::ASN_NVM_B_BITS-1:0] nvm_loader_b_defect,
  // reference clock monitor
  input  wire logic       xo_clock_loss,
  input  wire logic       cmon_inner_lock_loss
);
  import asn_pkg::*;

  localparam int NBITS = ASN_NGRP * ASN_DW;

  typedef struct packed {
    logic [7:0]                   page;
    logic [ASN_NGRP-1:0][7:0]     sticky;
    logic [ASN_NGRP-1:0][7:0]     enable;
    logic [ASN_NGRP-1:0][7:0]     irq_sel;
    logic [7:0]                   rdata;
    logic                         rvalid;
    logic                         irq_n;
  } asn_dev_state_type;

  localparam asn_dev_state_type ST_RESET = '{
    page:    ASN_PAGE_RESET,
    sticky:  {ASN_NGRP{ASN_STICKY_RESET}},
    enable:  {ASN_NGRP{ASN_ENABLE_RESET}},
    irq_sel: {ASN_NGRP{ASN_IRQSEL_RESET}},
    rdata:   '0,
    rvalid:  1'b0,
    irq_n:   ASN_IRQ_N_RESET
  };

  asn_dev_state_type         st;
  asn_dev_state_type         next_st;
  logic [ASN_NGRP-1:0][7:0]  defect;
  logic [NBITS-1:0]          live;
  logic [NBITS-1:0]          rise;
  logic [ASN_NGRP-1:0][7:0]  live_grp;
  logic [ASN_NGRP-1:0][7:0]  rise_grp;
  logic [ASN_NGRP-1:0]       hit_status;
  logic [ASN_NGRP-1:0]       hit_sticky;
  logic [ASN_NGRP-1:0]       hit_enable;
  logic [ASN_NGRP-1:0]       hit_irqsel;
  logic                      on_alarm_page;
  logic                      wr;
  logic                      rd;
  logic [7:0]                rd_val;
  logic [7:0]                clr;
  logic [7:0]                set;

  // one-hot match of an offset against a table of group offsets
  function automatic logic [ASN_NGRP-1:0] match_group(
    input logic [7:0]               a,
    input logic [ASN_NGRP-1:0][7:0] tbl
  );
    logic [ASN_NGRP-1:0] hit;
    hit = '0;
    for (int g = 0; g < ASN_NGRP; g++) begin
      hit[g] = (a == tbl[g]);
    end
    return hit;
  endfunction

  // defect sources at their register bit positions; unused bits zero
  assign defect[ASN_GRP_OUTER] = {4'h0, outer_lock_loss};
  assign defect[ASN_GRP_HOLD]  = {4'h0, pll3_holdover_hold, pll2_holdover_hold,
                                  pll1_holdover_hold, pll0_holdover_hold};
  assign defect[ASN_GRP_INNER] = {4'h0, inner_lock_loss};
  assign defect[ASN_GRP_NVM_A] = {nvm_dev_addr_error, nvm_word_addr_error,
                                  nvm_size_error, nvm_device_ident_error,
                                  nvm_page_ident_error, nvm_arb_lost,
                                  nvm_crc_error, nvm_read_done};
  assign defect[ASN_GRP_NVM_B] = {3'h0, nvm_loader_b_defect};

  // reference group: bits other than the two monitor flags read zero
  assign defect[ASN_GRP_REF] = (8'(xo_clock_loss) << ASN_REF_XO_BIT)
                             | (8'(cmon_inner_lock_loss) << ASN_REF_CMON_BIT);

  // sources may be asynchronous, so synchronise before edge detection
  asn_sync_edge #(
    .WIDTH  (NBITS),
    .STAGES (SYNC_STAGES)
  ) i_asn_sync_edge (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in (defect),
    .level    (live),
    .rise     (rise)
  );

  assign live_grp = live;
  assign rise_grp = rise;

  // address decode; alarm registers exist on the alarm page only
  assign on_alarm_page = (st.page == ASN_ALARM_PAGE);
  assign wr            = bus.req_wr;
  assign rd            = bus.req_rd & ~bus.req_wr; // write wins if both are raised
  assign hit_status    = on_alarm_page ? match_group(bus.addr, ASN_STATUS_OFFS) : '0;
  assign hit_sticky    = on_alarm_page ? match_group(bus.addr, ASN_STICKY_OFFS) : '0;
  assign hit_enable    = on_alarm_page ? match_group(bus.addr, ASN_ENABLE_OFFS) : '0;
  assign hit_irqsel    = on_alarm_page ? match_group(bus.addr, ASN_IRQSEL_OFFS) : '0;

  // read multiplexer; unmapped offsets and other pages read zero, except the page select, which reads on every page
  always_comb begin
    rd_val = '0;
    if (bus.addr == ASN_PAGE_SEL_OFF) begin
      rd_val = st.page;
    end
    for (int g = 0; g < ASN_NGRP; g++) begin
      if (hit_status[g]) begin
        rd_val = live_grp[g];
      end
      if (hit_sticky[g]) begin
        rd_val = st.sticky[g];
      end
      if (hit_enable[g]) begin
        rd_val = st.enable[g];
      end
      if (hit_irqsel[g]) begin
        rd_val = st.irq_sel[g];
      end
    end
  end

  // next state of every register
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    clr            = '0;
    set            = '0;
    // page select is reachable from every page
    if (wr && bus.addr == ASN_PAGE_SEL_OFF) begin
      next_st.page = bus.wdata;
    end
    for (int g = 0; g < ASN_NGRP; g++) begin
      // status offsets take no write
      clr = (wr && hit_sticky[g]) ? bus.wdata : 8'h00;
      set = rise_grp[g] & st.enable[g];
      // set wins over a clear arriving in the same cycle
      next_st.sticky[g] = (st.sticky[g] & ~clr) | set;
      if (wr && hit_enable[g]) begin
        next_st.enable[g] = bus.wdata;
      end
      if (wr && hit_irqsel[g]) begin
        next_st.irq_sel[g] = bus.wdata;
      end
    end
    if (rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
    end
    // pin is registered from the next stickies, so it moves on the same tick as they do
    next_st.irq_n = ~(|(next_st.sticky & next_st.irq_sel));
  end

  // everything advances on the 4 MHz tick only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= ST_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign bus.rdata  = st.rdata;
  assign bus.rvalid = st.rvalid;
  assign bus.irq_n  = st.irq_n;
endmodule

// [inc/asn_pkg.sv]
// asn_pkg: constants shared by the alarm block, its host end and the sync cell
// assumes one system clock; the alarm logic advances on a 4 MHz enable tick
package asn_pkg;
  localparam int ASN_DW   = 8;                  // register width
  localparam int ASN_NGRP = 6;                  // alarm register groups

  // group index inside the packed offset tables below
  localparam int ASN_GRP_OUTER = 0;
  localparam int ASN_GRP_HOLD  = 1;
  localparam int ASN_GRP_INNER = 2;
  localparam int ASN_GRP_NVM_A = 3;
  localparam int ASN_GRP_NVM_B = 4;
  localparam int ASN_GRP_REF   = 5;

  // page handling
  localparam logic [7:0] ASN_PAGE_SEL_OFF = 8'hff;
  localparam logic [7:0] ASN_ALARM_PAGE   = 8'h00;
  localparam logic [7:0] ASN_PAGE_RESET   = 8'h00;

  // offsets, entry g is group g
  localparam logic [ASN_NGRP-1:0][7:0] ASN_STATUS_OFFS =
    {8'h9d, 8'h9a, 8'h96, 8'h92, 8'h0a, 8'h06};
  localparam logic [ASN_NGRP-1:0][7:0] ASN_STICKY_OFFS =
    {8'h9e, 8'h9b, 8'h97, 8'h93, 8'h0b, 8'h07};
  localparam logic [ASN_NGRP-1:0][7:0] ASN_ENABLE_OFFS =
    {8'h9f, 8'h9c, 8'h98, 8'h94, 8'h0c, 8'h08};
  localparam logic [ASN_NGRP-1:0][7:0] ASN_IRQSEL_OFFS =
    {8'he5, 8'he4, 8'he3, 8'he2, 8'he1, 8'he0};

  // field positions
  localparam int ASN_PLL_BITS     = 4;          // pll alarms sit in bits 3:0
  localparam int ASN_NVM_B_BITS   = 5;          // loader group b uses bits 4:0
  localparam int ASN_REF_XO_BIT   = 4;
  localparam int ASN_REF_CMON_BIT = 5;

  // values after reset
  localparam logic [7:0] ASN_STICKY_RESET = 8'hff;
  localparam logic [7:0] ASN_ENABLE_RESET = 8'hff;
  localparam logic [7:0] ASN_IRQSEL_RESET = 8'hff;
  localparam logic [7:0] ASN_CLEAR_ALL    = 8'hff;
  localparam logic       ASN_IRQ_N_RESET  = 1'b0; // all stickies pending at reset

  // alarm logic clock, delivered as an enable of the system clock
  localparam int ASN_RC_CLOCK_HZ = 4_000_000;

  // host start-up: clear every sticky, then open every enable
  localparam int ASN_INIT_WRITES = 2 * ASN_NGRP;
endpackage

// [inc/asn_if.sv]
// asn_if: parallel register port and interrupt pin between host and alarm block
// assumes both ends share clk_sys and the same clock enable
`timescale 1ns/1ps
interface asn_if;
  logic       req_wr;   // write request, one enabled cycle
  logic       req_rd;   // read request, one enabled cycle
  logic [7:0] addr;     // offset within the selected page
  logic [7:0] wdata;    // write data
  logic [7:0] rdata;    // read data, valid with rvalid
  logic       rvalid;   // read answer pulse
  logic       irq_n;    // interrupt pin, low while a selected sticky is set

  modport dev  (input req_wr, req_rd, addr, wdata, output rdata, rvalid, irq_n);
  modport host (output req_wr, req_rd, addr, wdata, input rdata, rvalid, irq_n);
endinterface

// [rtl/asn_sync_edge.sv]
// asn_sync_edge: multi-stage synchroniser with rising-edge detection per bit
// assumes inputs may come from any clock domain; advances only on clk_en
`timescale 1ns/1ps
module asn_sync_edge #(
  parameter int WIDTH  = 8,
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  import asn_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
    logic [WIDTH-1:0]             prev;
  } asn_sync_state_type;

  asn_sync_state_type st;
  asn_sync_state_type next_st;

  // fewer than two stages would let metastability reach the edge detector
  if (STAGES < 2 || WIDTH < 1) begin : g_check
    $error("asn_sync_edge: STAGES must be at least 2 and WIDTH at least 1");
  end

  // stage 0 feeds only stage 1; the edge detector looks at the last stage
  always_comb begin
    next_st       = st;
    next_st.stage = {st.stage[STAGES-2:0], async_in};
    next_st.prev  = st.stage[STAGES-1];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign level = st.stage[STAGES-1];
  assign rise  = st.stage[STAGES-1] & ~st.prev; // a pulse sampled on one tick still leaves an edge
endmodule

// [rtl/asn_host.sv]
// asn_host: register-port master that tracks the page and runs alarm clears
// assumes the device end on asn_if.host, same clk_sys and clk_en
`timescale 1ns/1ps
module asn_host (
  // clock, reset and tick
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // register port and interrupt pin
  asn_if.host             bus,
  // user command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_page,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       clear_all,
  // user answer
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic      [7:0] cmd_rdata,
  output logic            init_done,
  output logic            alarm_pending
);
  import asn_pkg::*;

  typedef enum logic [2:0] {
    H_BOOT, H_BULK, H_IDLE, H_ACCESS, H_AWAIT
  } asn_host_phase_type;

  typedef struct packed {
    asn_host_phase_type phase;
    logic [7:0]         cur_page;
    logic [3:0]         idx;
    logic [3:0]         last;
    logic               cmd_write;
    logic [7:0]         cmd_addr;
    logic [7:0]         cmd_wdata;
    logic               req_wr;
    logic               req_rd;
    logic [7:0]         addr;
    logic [7:0]         wdata;
    logic               ready;
    logic               done;
    logic [7:0]         rdata;
    logic               init_done;
    logic               pending;
  } asn_host_state_type;

  asn_host_state_type st;
  asn_host_state_type next_st;

  // bulk sequence: stickies first, then enables
  function automatic logic [7:0] bulk_addr(input logic [3:0] i);
    if (i < 4'(ASN_NGRP)) begin
      return ASN_STICKY_OFFS[i];
    end
    return ASN_ENABLE_OFFS[4'(i - 4'(ASN_NGRP))];
  endfunction

  // requests are one enabled cycle long unless a state raises them again
  always_comb begin
    next_st         = st;
    next_st.req_wr  = 1'b0;
    next_st.req_rd  = 1'b0;
    next_st.done    = 1'b0;
    next_st.pending = ~bus.irq_n;
    unique case (st.phase)
      H_BOOT: begin
        // start-up and clear_all both begin by selecting the alarm page
        next_st.req_wr   = 1'b1;
        next_st.addr     = ASN_PAGE_SEL_OFF;
        next_st.wdata    = ASN_ALARM_PAGE;
        next_st.cur_page = ASN_ALARM_PAGE;
        next_st.idx      = '0;
        next_st.phase    = H_BULK;
      end
      H_BULK: begin
        next_st.req_wr = 1'b1;
        next_st.addr   = bulk_addr(st.idx);
        next_st.wdata  = ASN_CLEAR_ALL;
        next_st.idx    = 4'(st.idx + 4'd1);
        if (st.idx == st.last) begin
          next_st.phase     = H_IDLE;
          next_st.init_done = 1'b1;
        end
      end
      H_IDLE: begin
        if (clear_all) begin
          next_st.last  = 4'(ASN_NGRP - 1);
          next_st.phase = H_BOOT;
        end else if (cmd_valid) begin
          next_st.cmd_write = cmd_write;
          next_st.cmd_addr  = cmd_addr;
          next_st.cmd_wdata = cmd_wdata;
          next_st.phase     = H_ACCESS;
          // reselect only when the page differs; the device keeps it otherwise
          if (cmd_page != st.cur_page) begin
            next_st.req_wr   = 1'b1;
            next_st.addr     = ASN_PAGE_SEL_OFF;
            next_st.wdata    = cmd_page;
            next_st.cur_page = cmd_page;
          end
        end
      end
      H_ACCESS: begin
        next_st.req_wr = st.cmd_write;
        next_st.req_rd = ~st.cmd_write;
        next_st.addr   = st.cmd_addr;
        next_st.wdata  = st.cmd_wdata;
        if (st.cmd_write) begin
          next_st.done  = 1'b1;
          next_st.phase = H_IDLE;
          // a raw write to the page location moves the tracked page too
          if (st.cmd_addr == ASN_PAGE_SEL_OFF) begin
            next_st.cur_page = st.cmd_wdata;
          end
        end else begin
          next_st.phase = H_AWAIT;
        end
      end
      H_AWAIT: begin
        if (bus.rvalid) begin
          next_st.rdata = bus.rdata;
          next_st.done  = 1'b1;
          next_st.phase = H_IDLE;
        end
      end
    endcase
    next_st.ready = (next_st.phase == H_IDLE) && !clear_all;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st       <= '0;
      st.phase <= H_BOOT;
      st.last  <= 4'(ASN_INIT_WRITES - 1);
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign bus.req_wr    = st.req_wr;
  assign bus.req_rd    = st.req_rd;
  assign bus.addr      = st.addr;
  assign bus.wdata     = st.wdata;
  assign cmd_ready     = st.ready;
  assign cmd_done      = st.done;
  assign cmd_rdata     = st.rdata;
  assign init_done     = st.init_done;
  assign alarm_pending = st.pending;
endmodule

// [sim/asn_properties.sv]
// asn_properties: checks on the host-device register link
// assumes asn_if signals; state moves on clk_en only
`timescale 1ns/1ps
module asn_properties (
  // clock, reset and tick
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clk_en,
  // link
  input wire logic       req_wr,
  input wire logic       req_rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq_n
);
  import asn_pkg::*;
  typedef struct packed {
    logic [7:0]               page;
    logic [ASN_NGRP-1:0][7:0] en;
  } asn_mirror_type;
  asn_mirror_type mir;
  asn_mirror_type next_mir;
  logic           rd_go;
  logic           en_hit;
  logic [7:0]     en_val;
  logic           pll_stat;

  // mirror of page and enable writes
  always_comb begin
    next_mir = mir;
    en_hit = 1'b0;
    en_val = 8'h00;
    if (clk_en && req_wr && addr == ASN_PAGE_SEL_OFF) begin
      next_mir.page = wdata;
    end
    for (int g = 0; g < ASN_NGRP; g++) begin
      if (addr == ASN_ENABLE_OFFS[g]) begin
        en_hit = 1'b1;
        en_val = mir.en[g];
        if (clk_en && req_wr && mir.page == ASN_ALARM_PAGE) begin
          next_mir.en[g] = wdata;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mir <= {ASN_PAGE_RESET, {ASN_NGRP{ASN_ENABLE_RESET}}};
    end else begin
      mir <= next_mir;
    end
  end

  // a write wins over a read on the same edge
  assign rd_go    = clk_en && req_rd && !req_wr;
  assign pll_stat = addr == ASN_STATUS_OFFS[0] || addr == ASN_STATUS_OFFS[1]
                 || addr == ASN_STATUS_OFFS[2];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_rd_answer;
    rd_go |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_rvalid_cause;
    $rose(rvalid) |-> $past(rd_go);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read");
  property p_rdata_hold;
    !rd_go |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_tick_only;
    !clk_en |=> $stable(irq_n) && $stable(rvalid);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("output moved off the tick");
  property p_page_rb;
    rd_go && addr == ASN_PAGE_SEL_OFF |=> rdata == mir.page;
  endproperty
  a_page_rb: assert property (p_page_rb)
    else $error("page select read back wrong");
  property p_enable_rb;
    rd_go && mir.page == ASN_ALARM_PAGE && en_hit |=> rdata == $past(en_val);
  endproperty
  a_enable_rb: assert property (p_enable_rb)
    else $error("enable read back wrong");
  property p_off_page;
    rd_go && mir.page != ASN_ALARM_PAGE && addr != ASN_PAGE_SEL_OFF |=> rdata == 8'h00;
  endproperty
  a_off_page: assert property (p_off_page)
    else $error("alarm data seen on another page");
  property p_pll_unused;
    rd_go && mir.page == ASN_ALARM_PAGE && pll_stat |=> rdata[7:4] == 4'h0;
  endproperty
  a_pll_unused: assert property (p_pll_unused)
    else $error("pll status upper bits set");
  property p_reset_out;
    $fell(reset) |-> !irq_n && !rvalid && rdata == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("wrong outputs after reset");
endmodule

// [sim/alarm_status_notify_mask_tb.sv]
// asn bench: host and device on link 0, bare device on link 1
// assumes nothing; link 1 plays a careless controller
`timescale 1ns/1ps
module alarm_status_notify_mask_tb;
  import asn_pkg::*;
  // pll groups use four bits, loader b five, reference clock bits 4 and 5
  localparam logic [ASN_NGRP-1:0][7:0] USED = {8'h30, 8'h1f, 8'hff, 8'h0f, 8'h0f, 8'h0f};
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_write = 1'b0;
  logic       clear_all = 1'b0;
  logic [7:0] cmd_page = 8'h00;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] rd;
  logic [7:0] cmd_rdata;
  logic       cmd_ready;
  logic       cmd_done;
  logic       init_done;
  logic       alarm_pending;
  int         miscompares = 0;
  int         total_checks = 0;
  int         tick_cnt = 0;
  // defect inputs per group
  logic [ASN_NGRP-1:0][7:0] dfx = '0;

  // 200 MHz system clock; the 4 MHz alarm tick is one cycle in fifty
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    #1;
    tick_cnt = (tick_cnt + 1) % 50;
    clk_en = (tick_cnt == 0);
  end

  // both devices see the same defects; only link 0 has a host
  asn_if lnk [2] ();
  for (genvar k = 0; k < 2; k++) begin : dev
    asn_device i_asn_device (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .bus(lnk[k]),
      .outer_lock_loss(dfx[0][3:0]), .inner_lock_loss(dfx[2][3:0]),
      .pll0_holdover_hold(dfx[1][0]), .pll1_holdover_hold(dfx[1][1]),
      .pll2_holdover_hold(dfx[1][2]), .pll3_holdover_hold(dfx[1][3]),
      .nvm_read_done(dfx[3][0]), .nvm_crc_error(dfx[3][1]), .nvm_arb_lost(dfx[3][2]),
      .nvm_page_ident_error(dfx[3][3]), .nvm_device_ident_error(dfx[3][4]),
      .nvm_size_error(dfx[3][5]), .nvm_word_addr_error(dfx[3][6]),
      .nvm_dev_addr_error(dfx[3][7]), .nvm_loader_b_defect(dfx[4][4:0]),
      .xo_clock_loss(dfx[5][4]), .cmon_inner_lock_loss(dfx[5][5])
    );
  end
  asn_host i_asn_host (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .bus(lnk[0]),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .clear_all(clear_all),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
    .init_done(init_done), .alarm_pending(alarm_pending)
  );
  asn_properties i_asn_properties (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .req_wr(lnk[0].req_wr),
    .req_rd(lnk[0].req_rd), .addr(lnk[0].addr), .wdata(lnk[0].wdata),
    .rdata(lnk[0].rdata), .rvalid(lnk[0].rvalid), .irq_n(lnk[0].irq_n)
  );

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // land just after the next enabled edge; negedge sampling avoids races
  task automatic tick(input int n = 1);
    repeat (n) begin
      do @(negedge clk_sys); while (clk_en !== 1'b1);
      @(posedge clk_sys);
      #1;
    end
  endtask

  // one host command, held until taken
  task automatic op(input logic wr, input logic [7:0] pg, input logic [7:0] ad,
                    input logic [7:0] wd);
    int n = 0;
    while (cmd_ready !== 1'b1 && n < 99) begin
      tick();
      n++;
    end
    {cmd_write, cmd_page, cmd_addr, cmd_wdata} = {wr, pg, ad, wd};
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && n < 99) begin
      tick();
      n++;
    end
    if (n >= 99) chk("host timeout", 8'h00, 8'h01);
    rd = cmd_rdata;
  endtask
  task automatic rd0(input logic [7:0] ad);
    op(1'b0, ASN_ALARM_PAGE, ad, 8'h00);
  endtask
  task automatic wr0(input logic [7:0] ad, input logic [7:0] wd);
    op(1'b1, ASN_ALARM_PAGE, ad, wd);
  endtask

  // bare link access, one enabled cycle
  task automatic raw_op(input logic wr, input logic [7:0] ad, input logic [7:0] wd);
    tick();
    {lnk[1].req_wr, lnk[1].req_rd, lnk[1].addr, lnk[1].wdata} = {wr, !wr, ad, wd};
    tick();
    {lnk[1].req_wr, lnk[1].req_rd} = 2'b00;
    if (!wr) chk("raw answer", 8'(lnk[1].rvalid), 8'h01);
    rd = lnk[1].rdata;
  endtask
  task automatic wait_init();
    for (int i = 0; i < 99 && init_done !== 1'b1; i++) tick();
    chk("init", 8'(init_done), 8'h01);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // run needs about 20k cycles; cut a hang at 80k
  initial begin
    #400_000;
    miscompares++;
    results();
  end

  initial begin
    {lnk[1].req_wr, lnk[1].req_rd, lnk[1].addr, lnk[1].wdata} = '0;
    repeat (16) @(posedge clk_sys);
    chk("irq in reset", 8'(lnk[0].irq_n), 8'h00);
    #1;
    reset = 1'b0;
    // careless controller: nothing cleared
    for (int g = 0; g < ASN_NGRP; g++) begin
      raw_op(1'b0, ASN_STICKY_OFFS[g], 8'h00);
      chk("raw sticky", rd, 8'hff);
      raw_op(1'b0, ASN_ENABLE_OFFS[g], 8'h00);
      chk("raw enable", rd, 8'hff);
    end
    raw_op(1'b1, ASN_STICKY_OFFS[0], 8'h00);
    raw_op(1'b0, ASN_STICKY_OFFS[0], 8'h00);
    chk("zero write", rd, 8'hff);
    chk("raw irq", 8'(lnk[1].irq_n), 8'h00);
    raw_op(1'b1, ASN_STATUS_OFFS[3], 8'hff);
    raw_op(1'b0, ASN_STATUS_OFFS[3], 8'h00);
    chk("status write", rd, 8'h00);
    wait_init();
    chk("irq boot", 8'(lnk[0].irq_n), 8'h01);
    // per group: crossing patterns, hold, clear
    for (int g = 0; g < ASN_NGRP; g++) begin
      rd0(ASN_ENABLE_OFFS[g]);
      chk("enable", rd, 8'hff);
      rd0(ASN_STICKY_OFFS[g]);
      chk("boot sticky", rd, 8'h00);
      dfx[g] = 8'ha5;
      tick(4);
      rd0(ASN_STATUS_OFFS[g]);
      chk("status", rd, 8'ha5 & USED[g]);
      rd0(ASN_STICKY_OFFS[g]);
      chk("sticky", rd, 8'ha5 & USED[g]);
      chk("irq", 8'(lnk[0].irq_n), 8'h00);
      chk("pending", 8'(alarm_pending), 8'h01);
      dfx[g] = 8'h5a;
      tick(4);
      rd0(ASN_STATUS_OFFS[g]);
      chk("status", rd, 8'h5a & USED[g]);
      dfx[g] = 8'h00;
      tick(4);
      rd0(ASN_STATUS_OFFS[g]);
      chk("status", rd, 8'h00);
      wr0(ASN_STICKY_OFFS[g], 8'h00);
      rd0(ASN_STICKY_OFFS[g]);
      chk("sticky", rd, USED[g]);
      wr0(ASN_STICKY_OFFS[g], 8'hff);
      rd0(ASN_STICKY_OFFS[g]);
      chk("cleared", rd, 8'h00);
      chk("irq", 8'(lnk[0].irq_n), 8'h01);
    end
    // masked bit 0, one-tick pulses, set again after clear
    wr0(ASN_ENABLE_OFFS[0], 8'h0e);
    rd0(ASN_ENABLE_OFFS[0]);
    chk("enable", rd, 8'h0e);
    for (int k = 0; k < 2; k++) begin
      dfx[0] = 8'h0f;
      tick();
      dfx[0] = 8'h00;
      tick(4);
      rd0(ASN_STICKY_OFFS[0]);
      chk("masked", rd, 8'h0e);
      wr0(ASN_STICKY_OFFS[0], 8'hff);
    end
    // holdover group taken off the pin, reference group left on it
    wr0(ASN_IRQSEL_OFFS[1], 8'h00);
    dfx[1] = 8'h01;
    tick(4);
    dfx[1] = 8'h00;
    rd0(ASN_STICKY_OFFS[1]);
    chk("unselected", rd, 8'h01);
    chk("irq", 8'(lnk[0].irq_n), 8'h01);
    dfx[5] = 8'h10;
    tick(4);
    dfx[5] = 8'h00;
    tick(4);
    chk("irq", 8'(lnk[0].irq_n), 8'h00);
    clear_all = 1'b1;
    tick();
    clear_all = 1'b0;
    for (int i = 0; i < 99 && cmd_ready !== 1'b1; i++) tick();
    tick();
    chk("irq", 8'(lnk[0].irq_n), 8'h01);
    rd0(ASN_STICKY_OFFS[1]);
    chk("clear all", rd, 8'h00);
    // paging: page 1 holds no alarm registers
    op(1'b1, 8'h01, ASN_ENABLE_OFFS[2], 8'h00);
    op(1'b0, 8'h01, ASN_ENABLE_OFFS[2], 8'h00);
    chk("page 1", rd, 8'h00);
    op(1'b0, 8'h01, ASN_PAGE_SEL_OFF, 8'h00);
    chk("page sel", rd, 8'h01);
    rd0(ASN_ENABLE_OFFS[2]);
    chk("page 0", rd, 8'hff);
    // second reset in mid-run
    reset = 1'b1;
    tick();
    chk("irq in reset", 8'(lnk[0].irq_n), 8'h00);
    reset = 1'b0;
    raw_op(1'b0, ASN_STICKY_OFFS[5], 8'h00);
    chk("raw sticky", rd, 8'hff);
    wait_init();
    chk("irq boot", 8'(lnk[0].irq_n), 8'h01);
    results();
  end
endmodule
